// *** arpb_pkg.sv ***
// constants shared by the route, gain, pack and biquad filter logic
// assumes a single clock domain and signed 32-bit audio samples
package arpb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets on the Avalon-MM slave
    localparam logic [5:0] OFS_ROUTE_BASE = 6'h00;
    localparam logic [5:0] OFS_FILT_SEL = 6'h20;
    localparam logic [5:0] OFS_FILT_SKIP = 6'h24;
    localparam logic [5:0] OFS_COEF_PTR = 6'h28;
    localparam logic [5:0] OFS_COEF_FIXED = 6'h2C;
    localparam logic [5:0] OFS_COEF_FLOAT = 6'h30;
    localparam logic [5:0] OFS_PACK_CFG = 6'h34;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int SRC_LSB = 0;
    localparam int SHIFT_LSB = 8;
    localparam int CFG_USB_BUILD = 0;
    localparam int CFG_WIDTH_LSB = 1;

    ////////////////////////////////////////////////////////////////////////////
    // sizes and codes
    localparam int NUM_DEST = 8;
    localparam int NUM_FILT = 8;
    localparam int NUM_COEF = 10;
    localparam int COEF_PER_SECT = 5;
    localparam int COEF_FRAC = 28;
    localparam logic [3:0] COEF_LAST = 4'h9;
    localparam logic [4:0] SRC_MUTE = 5'h00;
    localparam logic [4:0] SRC_USB_AVG = 5'h01;
    localparam logic [4:0] SRC_USB_DIF = 5'h02;
    localparam logic [4:0] SRC_I2S_AVG = 5'h03;
    localparam logic [4:0] SRC_I2S_DIF = 5'h04;
    localparam logic [4:0] SRC_PIPE0 = 5'h05;
    localparam logic [4:0] SRC_PIPE1 = 5'h06;
    localparam logic [4:0] SRC_USB0 = 5'h07;
    localparam logic [4:0] SRC_USB1 = 5'h08;
    localparam logic [4:0] SRC_I2S0 = 5'h09;
    localparam logic [4:0] SRC_I2S1 = 5'h0A;
    localparam logic [4:0] SRC_MIC0 = 5'h0B;
    localparam logic [4:0] SRC_MIC1 = 5'h0C;
    localparam logic [4:0] SRC_PACK_PIPE = 5'h0D;
    localparam logic [4:0] SRC_PACK_MIC = 5'h0E;
    localparam logic [4:0] SRC_PACK_REF = 5'h0F;
    localparam logic [4:0] SRC_PACK_ALL = 5'h10;
    localparam logic [4:0] SRC_PACK_IN_USB = 5'h11;
    localparam logic [4:0] SRC_PACK_IN_I2S = 5'h12;
    localparam logic [4:0] SRC_LAST = 5'h12;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [4:0] RST_SRC [NUM_DEST] = '{SRC_PIPE0, SRC_PIPE1, SRC_PIPE0, SRC_I2S0,
        SRC_USB0, SRC_USB1, SRC_MIC0, SRC_MIC1};
    localparam logic signed [7:0] RST_SHIFT = 8'h00;
    localparam logic [7:0] RST_SKIP = 8'hFF;
    localparam logic [2:0] RST_CFG = 3'h4;
    localparam logic signed [31:0] SAMPLE_MAX = 32'h7FFFFFFF;
    localparam logic signed [31:0] SAMPLE_MIN = 32'h80000000;

    typedef enum logic [1:0] {PH0 = 2'b00, PH1 = 2'b01, PH2 = 2'b11} arpb_phase_t;

    // clamp a wide signed value into a 32-bit sample
    function automatic logic signed [31:0] arpb_sat(input logic signed [66:0] v);
        if (v > 67'(SAMPLE_MAX))
            return SAMPLE_MAX;
        else if (v < 67'(SAMPLE_MIN))
            return SAMPLE_MIN;
        else
            return v[31:0];
    endfunction

endpackage

// *** arpb_biquad_pair.sv ***
// two cascaded biquad sections with bypass, coefficient store and history clear
// assumes one sample strobe at the path's own rate and coefficients in Q4.28
module arpb_biquad_pair (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sampleStb,
    input wire logic signed [31:0] sampleIn,
    input wire logic skip,
    input wire logic coefWr,
    input wire logic [3:0] coefIdx,
    input wire logic [31:0] coefData,
    input wire logic clearHist,
    output logic [31:0] coefRd,
    output logic signed [31:0] sampleOut
);
    logic signed [31:0] coef [arpb_pkg::NUM_COEF];
    logic signed [31:0] x1, x2, y1, y2, z1, z2;
    logic signed [31:0] sect1, sect2;

    // coefficients are stored sign-inverted for a1 and a2, so every term adds
    function automatic logic signed [31:0] biquad(input logic signed [31:0] x, xa, xb, ya, yb,
        input int base);
        logic signed [66:0] acc;
        acc = 67'(coef[base+2]) * 67'(x) + 67'(coef[base+3]) * 67'(xa)
            + 67'(coef[base+4]) * 67'(xb) + 67'(coef[base]) * 67'(ya)
            + 67'(coef[base+1]) * 67'(yb);
        return arpb_pkg::arpb_sat(acc >>> arpb_pkg::COEF_FRAC);
    endfunction

    always_comb
    begin
        sect1 = biquad(sampleIn, x1, x2, y1, y2, 0);
        sect2 = biquad(sect1, y1, y2, z1, z2, arpb_pkg::COEF_PER_SECT);
    end

    assign coefRd = coef[coefIdx];

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < arpb_pkg::NUM_COEF; i++)
                coef[i] <= 32'h00000000;
        end
        else if (coefWr)
            coef[coefIdx] <= coefData;
    end

    // a half-applied coefficient set could ring forever, so history is wiped
    always_ff @(posedge clk)
    begin
        if (!rst_b || clearHist)
        begin
            x1 <= 32'h00000000;
            x2 <= 32'h00000000;
            y1 <= 32'h00000000;
            y2 <= 32'h00000000;
            z1 <= 32'h00000000;
            z2 <= 32'h00000000;
        end
        else if (sampleStb && !skip)
        begin
            x1 <= sampleIn;
            x2 <= x1;
            y1 <= sect1;
            y2 <= y1;
            z1 <= sect2;
            z2 <= z1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            sampleOut <= 32'h00000000;
        else if (sampleStb)
            sampleOut <= skip ? sampleIn : sect2;
    end

    ////////////////////////////////////////////////////////////////////////////
    hist_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        clearHist |=> (x1 == 32'h00000000 && y1 == 32'h00000000 && z2 == 32'h00000000))
        else $error("history not cleared after coefficient update");
    bypass_pass_a: assert property (@(posedge clk) disable iff (!rst_b)
        sampleStb && skip |=> sampleOut == $past(sampleIn))
        else $error("bypassed filter altered its sample");
endmodule

// *** audio_route_pack_biquad.sv ***
// routing matrix, shift gain, six-channel packer and eight biquad filter blocks
// assumes an Avalon-MM master, tick16 at 16 kHz and tickOut at the output rate
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
module audio_route_pack_biquad (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic tick16,
    input wire logic tickOut,
    input wire logic signed [31:0] srcPipe0,
    input wire logic signed [31:0] srcPipe1,
    input wire logic signed [31:0] srcUsb0,
    input wire logic signed [31:0] srcUsb1,
    input wire logic signed [31:0] srcI2s0,
    input wire logic signed [31:0] srcI2s1,
    input wire logic signed [31:0] srcMic0,
    input wire logic signed [31:0] srcMic1,
    output logic signed [31:0] usbOut0,
    output logic signed [31:0] usbOut1,
    output logic signed [31:0] i2sOut0,
    output logic signed [31:0] i2sOut1,
    output logic signed [31:0] refPipe0,
    output logic signed [31:0] refPipe1,
    output logic signed [31:0] micPipe0,
    output logic signed [31:0] micPipe1
);
    logic [4:0] srcSel [arpb_pkg::NUM_DEST];
    logic signed [7:0] shiftSel [arpb_pkg::NUM_DEST];
    logic [7:0] skip;
    logic [2:0] filtSel;
    logic [3:0] coefPtr;
    logic [2:0] packCfg;
    logic respond;
    arpb_pkg::arpb_phase_t phase;
    logic request, accept, accWrite, accRead;
    logic accRoute, accCoef;
    logic [2:0] accDest;
    logic [31:0] coefWord;
    logic [31:0] routeWord;
    logic [31:0] regRead;
    logic [4:0] markPos;
    logic signed [31:0] slot [6];
    logic signed [31:0] routed [arpb_pkg::NUM_DEST];
    logic signed [31:0] gained [arpb_pkg::NUM_DEST];
    logic signed [31:0] filtOut [arpb_pkg::NUM_FILT];
    logic [31:0] coefRd [arpb_pkg::NUM_FILT];
    logic signed [31:0] destOut [arpb_pkg::NUM_DEST];

    ////////////////////////////////////////////////////////////////////////////
    // helper functions

    function automatic logic [31:0] mergeBytes(input logic [31:0] old, wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (be[b])
                r[8*b +: 8] = wd[8*b +: 8];
        return r;
    endfunction

    // filter ids put the mic blocks before the reference blocks
    function automatic logic [2:0] filtOfDest(input int d);
        case (d)
            4: return 3'h6;
            5: return 3'h7;
            6: return 3'h4;
            7: return 3'h5;
            default: return 3'(d);
        endcase
    endfunction

    // truncate to the packed width and plant the alignment marker
    function automatic logic signed [31:0] marked(input logic signed [31:0] x, input logic mark);
        logic signed [31:0] r;
        r = x & (32'hFFFFFFFF << markPos);
        r[markPos] = mark;
        return r;
    endfunction

    function automatic logic signed [31:0] half(input logic signed [31:0] a, b, input logic neg);
        logic signed [32:0] s;
        s = neg ? (33'(a) - 33'(b)) : (33'(a) + 33'(b));
        return s[32:1];
    endfunction

    // IEEE single to Q4.28, clamped; denormals and tiny values become zero
    function automatic logic signed [31:0] floatToQ(input logic [31:0] f);
        logic [63:0] mag;
        logic signed [9:0] sh;
        sh = $signed({2'b00, f[30:23]}) - 10'sd122;
        mag = 64'h0000000000000000;
        if (f[30:23] == 8'h00)
            mag = 64'h0000000000000000;
        else if (sh >= 10'sd8)
            mag = 64'h000000007FFFFFFF;
        else if (sh >= 10'sd0)
            mag = {40'h0000000000, 1'b1, f[22:0]} << sh[2:0];
        else if (sh > -10'sd24)
            mag = {40'h0000000000, 1'b1, f[22:0]} >> 5'(-sh);
        if (mag > 64'h000000007FFFFFFF)
            mag = 64'h000000007FFFFFFF;
        return f[31] ? -$signed(mag[31:0]) : $signed(mag[31:0]);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: first edge latches the answer, second edge completes
    assign request = avs_read || avs_write;
    assign avs_waitrequest = request && !respond;
    assign accept = request && respond;
    assign accWrite = accept && avs_write;
    assign accRead = accept && avs_read;
    assign accRoute = avs_address < arpb_pkg::OFS_FILT_SEL;
    assign accDest = avs_address[4:2];
    assign accCoef = avs_address == arpb_pkg::OFS_COEF_FIXED
        || avs_address == arpb_pkg::OFS_COEF_FLOAT;
    assign routeWord = mergeBytes(regRead, avs_writedata, avs_byteenable);

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            respond <= 1'b0;
        else
            respond <= request && !respond;
    end

    always_comb
    begin
        regRead = 32'h00000000;
        if (accRoute)
            regRead = {16'h0000, shiftSel[accDest], 3'h0, srcSel[accDest]};
        else
            case (avs_address)
                arpb_pkg::OFS_FILT_SEL: regRead = {29'h0, filtSel};
                arpb_pkg::OFS_FILT_SKIP: regRead = {31'h0, skip[filtSel]};
                arpb_pkg::OFS_COEF_PTR: regRead = {28'h0, coefPtr};
                arpb_pkg::OFS_COEF_FIXED: regRead = coefRd[filtSel];
                arpb_pkg::OFS_COEF_FLOAT: regRead = coefRd[filtSel];
                arpb_pkg::OFS_PACK_CFG: regRead = {29'h0, packCfg};
                default: regRead = 32'h00000000;
            endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            avs_readdata <= 32'h00000000;
        else if (request && !respond)
            avs_readdata <= avs_read ? regRead : 32'h00000000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // route table
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            for (int d = 0; d < arpb_pkg::NUM_DEST; d++)
            begin
                srcSel[d] <= arpb_pkg::RST_SRC[d];
                shiftSel[d] <= arpb_pkg::RST_SHIFT;
            end
        end
        else if (accWrite && accRoute)
        begin
            // destination comes from the address, source from the data
            if (routeWord[4:0] <= arpb_pkg::SRC_LAST)
                srcSel[accDest] <= routeWord[4:0];
            shiftSel[accDest] <= routeWord[15:8];
            if (routeWord[4:0] == arpb_pkg::SRC_PACK_ALL && accDest < 3'h4)
                srcSel[accDest ^ 3'h1] <= arpb_pkg::SRC_PACK_ALL;
        end
    end

    // filter control and coefficient pointer
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            filtSel <= 3'h0;
            skip <= arpb_pkg::RST_SKIP;
            coefPtr <= 4'h0;
            packCfg <= arpb_pkg::RST_CFG;
        end
        else if (accWrite && avs_address == arpb_pkg::OFS_FILT_SEL && avs_byteenable[0])
            filtSel <= avs_writedata[2:0];
        else if (accWrite && avs_address == arpb_pkg::OFS_FILT_SKIP && avs_byteenable[0])
            skip[filtSel] <= avs_writedata[0];
        else if (accWrite && avs_address == arpb_pkg::OFS_PACK_CFG && avs_byteenable[0])
            packCfg <= avs_writedata[2:0];
        else if (accWrite && avs_address == arpb_pkg::OFS_COEF_PTR && avs_byteenable[0])
            coefPtr <= (avs_writedata[3:0] > arpb_pkg::COEF_LAST) ? 4'h0 : avs_writedata[3:0];
        else if (accept && accCoef)
            coefPtr <= (coefPtr == arpb_pkg::COEF_LAST) ? 4'h0 : coefPtr + 4'h1;
    end

    // the first two of each five are the feedback terms, held negated
    always_comb
    begin
        if (avs_address == arpb_pkg::OFS_COEF_FLOAT)
            coefWord = (coefPtr % 5 < 2) ? -floatToQ(avs_writedata)
                : floatToQ(avs_writedata);
        else
            coefWord = avs_writedata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pack phase: three output frames per 16 kHz frame
    always_ff @(posedge clk)
    begin
        if (!rst_b || tick16)
            phase <= arpb_pkg::PH0;
        else if (tickOut)
            case (phase)
                arpb_pkg::PH0: phase <= arpb_pkg::PH1;
                arpb_pkg::PH1: phase <= arpb_pkg::PH2;
                default: phase <= arpb_pkg::PH0;
            endcase
    end

    always_comb
    begin
        case (packCfg[2:1])
            2'h0: markPos = 5'h10;
            2'h1: markPos = 5'h08;
            default: markPos = 5'h00;
        endcase
        if (!packCfg[arpb_pkg::CFG_USB_BUILD])
            markPos = 5'h00;
        slot[0] = marked(destOut[7], 1'b1);
        slot[1] = marked(destOut[6], 1'b1);
        slot[2] = marked(destOut[4], 1'b0);
        slot[3] = marked(destOut[5], 1'b0);
        slot[4] = marked(srcPipe0, 1'b0);
        slot[5] = marked(srcPipe1, 1'b0);
    end

    ////////////////////////////////////////////////////////////////////////////
    // source select and shift gain per destination
    always_comb
    begin
        for (int d = 0; d < arpb_pkg::NUM_DEST; d++)
        begin
            case (srcSel[d])
                arpb_pkg::SRC_MUTE: routed[d] = 32'h00000000;
                arpb_pkg::SRC_USB_AVG: routed[d] = half(srcUsb0, srcUsb1, 1'b0);
                arpb_pkg::SRC_USB_DIF: routed[d] = half(srcUsb0, srcUsb1, 1'b1);
                arpb_pkg::SRC_I2S_AVG: routed[d] = half(srcI2s0, srcI2s1, 1'b0);
                arpb_pkg::SRC_I2S_DIF: routed[d] = half(srcI2s0, srcI2s1, 1'b1);
                arpb_pkg::SRC_PIPE0: routed[d] = srcPipe0;
                arpb_pkg::SRC_PIPE1: routed[d] = srcPipe1;
                arpb_pkg::SRC_USB0: routed[d] = srcUsb0;
                arpb_pkg::SRC_USB1: routed[d] = srcUsb1;
                arpb_pkg::SRC_I2S0: routed[d] = srcI2s0;
                arpb_pkg::SRC_I2S1: routed[d] = srcI2s1;
                // raw mics feed the mic destinations, a self-loop would never see audio
                arpb_pkg::SRC_MIC0: routed[d] = (d >= 6) ? srcMic0 : destOut[6];
                arpb_pkg::SRC_MIC1: routed[d] = (d >= 6) ? srcMic1 : destOut[7];
                arpb_pkg::SRC_PACK_PIPE: routed[d] = slot[4 + (d % 2)];
                arpb_pkg::SRC_PACK_MIC: routed[d] = slot[d % 2];
                arpb_pkg::SRC_PACK_REF: routed[d] = slot[2 + (d % 2)];
                arpb_pkg::SRC_PACK_ALL:
                    routed[d] = (phase == arpb_pkg::PH0) ? slot[d % 2]
                        : (phase == arpb_pkg::PH1) ? slot[2 + (d % 2)] : slot[4 + (d % 2)];
                default: // packed inputs carry mic and reference only
                    routed[d] = (phase == arpb_pkg::PH0) ? slot[d % 2]
                        : (phase == arpb_pkg::PH1) ? slot[2 + (d % 2)] : 32'h00000000;
            endcase
            if (shiftSel[d] >= 8'sd0)
                gained[d] = arpb_pkg::arpb_sat(67'(routed[d]) <<<
                    ((shiftSel[d] > 8'sd35) ? 6'd35 : 6'(shiftSel[d])));
            else
                gained[d] = routed[d] >>> ((shiftSel[d] < -8'sd31) ? 5'd31
                    : 5'(-shiftSel[d]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output filters run on tickOut, pipeline-input filters on tick16
    for (genvar d = 0; d < arpb_pkg::NUM_DEST; d++)
    begin : g_dest
        assign destOut[d] = filtOut[filtOfDest(d)];
    end

    for (genvar d = 0; d < arpb_pkg::NUM_DEST; d++)
    begin : g_filt
        arpb_biquad_pair u_filt (
            .clk(clk),
            .rst_b(rst_b),
            .sampleStb(d < 4 ? tickOut : tick16),
            .sampleIn(gained[d]),
            .skip(skip[filtOfDest(d)]),
            .coefWr(accWrite && accCoef && filtSel == filtOfDest(d)),
            .coefIdx(coefPtr),
            .coefData(coefWord),
            .clearHist(accWrite && accCoef && filtSel == filtOfDest(d)
                && coefPtr == arpb_pkg::COEF_LAST),
            .coefRd(coefRd[filtOfDest(d)]),
            .sampleOut(filtOut[filtOfDest(d)])
        );
    end

    assign usbOut0 = destOut[0];
    assign usbOut1 = destOut[1];
    assign i2sOut0 = destOut[2];
    assign i2sOut1 = destOut[3];
    assign refPipe0 = destOut[4];
    assign refPipe1 = destOut[5];
    assign micPipe0 = destOut[6];
    assign micPipe1 = destOut[7];

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence routeWrite16;
        accWrite && accRoute && avs_byteenable[0] && avs_writedata[4:0] == 5'h10
            && accDest < 3'h4;
    endsequence

    bus_answer_a: assert property (request && !respond |=> !avs_waitrequest)
        else $error("slave did not answer in one cycle");
    pack_partner_a: assert property (routeWrite16 |=> srcSel[$past(accDest) ^ 3'h1] == 5'h10)
        else $error("packed-all partner channel not set");
    default_route_a: assert property (@(posedge clk) $rose(rst_b) |-> srcSel[0] == 5'h05
        && srcSel[3] == 5'h09 && srcSel[4] == 5'h07 && shiftSel[2] == 8'sd0)
        else $error("default routing wrong after reset");
    skip_reset_a: assert property (@(posedge clk) $rose(rst_b) |-> skip == 8'hFF)
        else $error("filters not bypassed after reset");
    mute_zero_a: assert property (tickOut && srcSel[1] == 5'h00 && skip[1]
        |=> usbOut1 == 32'h00000000)
        else $error("muted destination not zero");
    left_shift_a: assert property (tickOut && srcSel[2] == 5'h09 && shiftSel[2] == 8'sd4
        && skip[2] && srcI2s0 < 32'sh00100000 && srcI2s0 > -32'sh00100000
        |=> i2sOut0 == $past(srcI2s0) * 16)
        else $error("left shift gain wrong");
    marker_bit_a: assert property (tickOut && srcSel[2] == 5'h10 && skip[2]
        && shiftSel[2] == 8'sd0 && !packCfg[0] |=> i2sOut0[0] == $past(phase == arpb_pkg::PH0))
        else $error("packed marker bit wrong");
    coef_wrap_a: assert property (accWrite && accCoef && coefPtr == 4'h9
        |=> coefPtr == 4'h0)
        else $error("coefficient pointer did not wrap after ten");
    phase_align_a: assert property (tick16 |=> phase == arpb_pkg::PH0)
        else $error("pack phase not aligned to 16k frame");
endmodule

// *** arpb_src_model.sv ***
// audio endpoint model: frame strobe and one held sample word per source
// assumes the bench changes the base value only well between frames
module arpb_src_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [31:0] val,
    output logic tick,
    output logic [31:0] src [8]
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt;
    // 16k output mode: one output tick per 16k frame
    always_ff @(posedge clk)
    begin
        cnt <= rst_b ? cnt + 4'h1 : 4'h0;
        tick <= rst_b && cnt == 4'hF;
    end
    // a distinct word on each source so that a wrong route shows
    always_comb
        for (int i = 0; i < 8; i++)
            src[i] = val + 32'(i);
endmodule

// *** test_audio_route_pack_biquad.sv ***
// self-checking bench for routing, shift gain and filter control
// assumes the endpoint model paces 16k frames every 16 clocks
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
    $display("BAD %0t got %h want %h", $time, a, e); end end
module test_audio_route_pack_biquad;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_b = 0, avs_read = 0, avs_write = 0, avs_waitrequest, tick;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, val = 32'h0, seed = 32'hE7A1;
    logic [31:0] src [8], o [8], cf [10], rq [$];
    logic [63:0] aq [$], e;
    logic [1:0] tk = 2'b00;
    int bad_count = 0, comparisons = 0;
    always #25 clk = ~clk;
    arpb_src_model arpb_src_model_inst (.clk(clk), .rst_b(rst_b), .val(val), .tick(tick),
        .src(src));
    audio_route_pack_biquad audio_route_pack_biquad_inst (.clk(clk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tick16(tick), .tickOut(tick),
        .srcPipe0(src[0]), .srcPipe1(src[1]), .srcUsb0(src[2]), .srcUsb1(src[3]),
        .srcI2s0(src[4]), .srcI2s1(src[5]), .srcMic0(src[6]), .srcMic1(src[7]),
        .usbOut0(o[0]), .usbOut1(o[1]), .i2sOut0(o[2]), .i2sOut1(o[3]),
        .refPipe0(o[4]), .refPipe1(o[5]), .micPipe0(o[6]), .micPipe1(o[7]));
    ////////////////////////////////////////////////////////////
    // read data is taken at the accepting rising edge, audio outputs at the falling edge
    always @(posedge clk)
        if (avs_read && avs_waitrequest === 1'b0 && rq.size() > 0)
        begin
            e = {32'h0, rq.pop_front()};
            `CHK({32'h0, avs_readdata}, e)
        end
    always @(negedge clk)
    begin
        tk <= {tk[0], tick};
        if (tk[1] && aq.size() > 0)
        begin
            e = aq.pop_front();
            `CHK({o[1], o[2]}, e)
        end
    end
    task automatic results();
        // a noted result that never showed up is a mismatch too
        bad_count += aq.size() + rq.size();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 40);
        if (avs_waitrequest !== 1'b0)
        begin
            bad_count++;
            results();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] x);
        rq.push_back(x);
        bus(1'b0, a, 32'h0);
    endtask
    // forty clocks, two and a half frames, settle the new setting before the expectation is noted
    task automatic au(input logic [31:0] u1, input logic [31:0] i0);
        repeat (40) @(posedge clk);
        aq.push_back({u1, i0});
        repeat (20) @(posedge clk);
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        for (int d = 0; d < 8; d++)
            rd(6'(4 * d), {27'h0, arpb_pkg::RST_SRC[d]});
        rd(arpb_pkg::OFS_FILT_SKIP, 32'h1);
        for (int i = 0; i < 10; i++)
            rd(arpb_pkg::OFS_COEF_FIXED, 32'h0);
        $display("test defaults done");
        val <= $random(seed) & 32'h000FFFF0;
        bus(1'b1, 6'h04, 32'h9);
        bus(1'b1, 6'h08, 32'h409);
        au(val + 32'h4, (val + 32'h4) << 4);
        bus(1'b1, 6'h08, 32'hFE09);
        rd(6'h08, 32'hFE09);
        au(val + 32'h4, (val + 32'h4) >> 2);
        bus(1'b1, 6'h04, 32'h0);
        au(32'h0, (val + 32'h4) >> 2);
        $display("test routing done");
        bus(1'b1, arpb_pkg::OFS_FILT_SEL, 32'h3);
        bus(1'b1, arpb_pkg::OFS_FILT_SKIP, 32'h0);
        rd(arpb_pkg::OFS_FILT_SKIP, 32'h0);
        for (int i = 0; i < 10; i++)
        begin
            cf[i] = $random(seed);
            bus(1'b1, arpb_pkg::OFS_COEF_FIXED, cf[i]);
        end
        for (int i = 0; i < 10; i++)
            rd(arpb_pkg::OFS_COEF_FIXED, cf[i]);
        bus(1'b1, arpb_pkg::OFS_COEF_FLOAT, 32'h3F800000);
        bus(1'b1, arpb_pkg::OFS_COEF_PTR, 32'h2);
        bus(1'b1, arpb_pkg::OFS_COEF_FLOAT, 32'h3F000000);
        bus(1'b1, arpb_pkg::OFS_COEF_PTR, 32'h0);
        rd(arpb_pkg::OFS_COEF_FLOAT, 32'hF0000000);
        rd(arpb_pkg::OFS_COEF_FIXED, cf[1]);
        rd(arpb_pkg::OFS_COEF_FIXED, 32'h08000000);
        bus(1'b1, arpb_pkg::OFS_FILT_SEL, 32'h0);
        rd(arpb_pkg::OFS_FILT_SKIP, 32'h1);
        bus(1'b1, 6'h08, 32'h10);
        rd(6'h0C, 32'h10);
        au(32'h0, (val + 32'h7) | 32'h1);
        bus(1'b1, arpb_pkg::OFS_PACK_CFG, 32'h3);
        rd(arpb_pkg::OFS_PACK_CFG, 32'h3);
        au(32'h0, ((val + 32'h7) & 32'hFFFFFE00) | 32'h100);
        $display("test filters done");
        results();
    end
endmodule
